// ---- rtl/ipia_regs.svh ----
`ifndef IPIA_REGS_SVH
`define IPIA_REGS_SVH

// ----------------------------------------------------------------
// image layout (offsets count from one)
// ----------------------------------------------------------------
`define IPIA_OFS_FIRST 8'h01
`define IPIA_OFS_STATUS 8'h01
`define IPIA_OFS_DUMMY_HDR 8'h02
`define IPIA_OFS_DI_LOW 8'h03
`define IPIA_OFS_DI_HIGH 8'h04
`define IPIA_OFS_SLOT_BASE 8'h05
`define IPIA_OFS_LAST 8'h94
`define IPIA_SLOT_QUALITY 5'h00
`define IPIA_SLOT_DUMMY 5'h01
`define IPIA_SLOT_DATA 5'h02
`define IPIA_SLOT_END 5'h11
`define IPIA_PD_BYTES 5'h10

// ----------------------------------------------------------------
// values
// ----------------------------------------------------------------
`define IPIA_STATUS_VALID 8'h01
`define IPIA_STATUS_INVALID 8'h00
`define IPIA_ZERO_BYTE 8'h00

`endif

// ---- rtl/ipia_pkg.sv ----
package ipia_pkg;

    // port operating mode
    typedef enum logic [1:0] {
        IPIA_MODE_OFF = 2'b00,
        IPIA_MODE_IOLINK = 2'b01,
        IPIA_MODE_DIG_IN = 2'b10,
        IPIA_MODE_DIG_OUT = 2'b11
    } ipia_mode_e;

    // packing of the two digital-input bytes
    typedef enum logic {
        IPIA_PACK_PORT = 1'b0,
        IPIA_PACK_PIN = 1'b1
    } ipia_pack_e;

    // everything one port contributes to the image
    typedef struct packed {
        ipia_mode_e mode;
        logic [7:0] port_quality_byte;
        logic [4:0] pd_len;
        logic [127:0] pd;
        logic dir_a;
        logic dir_b;
        logic channel_a_input;
        logic channel_b_input;
        logic channel_a_output;
        logic channel_b_output;
    } ipia_port_s;

    // one byte of the outgoing image
    typedef struct packed {
        logic [7:0] data;
        logic first;
        logic last;
    } ipia_beat_s;

    // sequencer states
    typedef enum logic {
        IPIA_ST_IDLE = 1'b0,
        IPIA_ST_SEND = 1'b1
    } ipia_state_e;

endpackage

// ---- rtl/ipia_fifo.sv ----
`timescale 1ns/1ps
module ipia_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // filling side
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    input wire logic [WIDTH-1:0] wr_data_in,
    // draining side
    output logic rd_valid_out,
    input wire logic rd_ready_in,
    output logic [WIDTH-1:0] rd_data_out
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic do_wr;
    logic do_rd;

    // full and empty follow the true occupancy
    assign wr_ready_out = (count != (AW+1)'(DEPTH));
    assign rd_valid_out = (count != '0);
    assign do_wr = wr_valid_in && wr_ready_out;
    assign do_rd = rd_valid_out && rd_ready_in;
    // storage is flip-flops, so read data comes straight from a register
    assign rd_data_out = mem[rd_ptr];

    // storage
    always_ff @(posedge clk_in) begin
        if (do_wr) begin
            mem[wr_ptr] <= wr_data_in;
        end
    end

    // pointers and occupancy
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count <= count + 1'b1;
            end else if (do_rd && !do_wr) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

// ---- rtl/ipia_assembler.sv ----
`timescale 1ns/1ps
`include "ipia_regs.svh"
module ipia_assembler #(
    parameter int NUM_PORTS = 8,
    parameter int FIFO_DEPTH = 8
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // cycle control
    input wire logic start_in,
    output logic busy_out,
    output logic done_out,
    // port state and configuration
    input wire ipia_pkg::ipia_port_s [NUM_PORTS-1:0] ports_in,
    input wire ipia_pkg::ipia_pack_e pack_sel_in,
    input wire logic di_valid_in,
    // image byte stream toward the fieldbus controller
    output logic img_valid_out,
    input wire logic img_ready_in,
    output ipia_pkg::ipia_beat_s img_out
);

    // ----------------------------------------------------------------
    // snapshot of the inputs
    // ----------------------------------------------------------------
    // one coherent copy per image, so a port changing mid-image cannot
    // tear the image; costs one flop per input bit
    ipia_pkg::ipia_port_s [NUM_PORTS-1:0] snap;
    ipia_pkg::ipia_pack_e snap_pack;
    logic snap_di_valid;

    ipia_pkg::ipia_state_e state;
    logic [7:0] ofs;
    logic [2:0] port_idx;
    logic [4:0] slot_idx;
    logic push;
    logic fifo_ready;
    logic take_start;
    logic at_last;
    ipia_pkg::ipia_beat_s beat;
    logic [9:0] fifo_rd;
    logic [7:0] di_low;
    logic [7:0] di_high;
    logic [7:0] slot_byte;
    logic [7:0] hdr_byte;

    // a start while an image is under way is ignored
    assign take_start = start_in && (state == ipia_pkg::IPIA_ST_IDLE);
    assign push = (state == ipia_pkg::IPIA_ST_SEND) && fifo_ready;
    assign at_last = (ofs == `IPIA_OFS_LAST);

    // capture on an accepted start only
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            snap <= '0;
            snap_pack <= ipia_pkg::IPIA_PACK_PORT;
            snap_di_valid <= 1'b0;
        end else if (take_start) begin
            snap <= ports_in;
            snap_pack <= pack_sel_in;
            snap_di_valid <= di_valid_in;
        end
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    // state advances only when the fifo takes a byte, so back-pressure
    // from the reader stalls the whole assembly
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= ipia_pkg::IPIA_ST_IDLE;
        end else begin
            case (state)
                ipia_pkg::IPIA_ST_IDLE: begin
                    if (take_start) begin
                        state <= ipia_pkg::IPIA_ST_SEND;
                    end
                end
                ipia_pkg::IPIA_ST_SEND: begin
                    if (push && at_last) begin
                        state <= ipia_pkg::IPIA_ST_IDLE;
                    end
                end
                default: begin
                    state <= ipia_pkg::IPIA_ST_IDLE;
                end
            endcase
        end
    end

    // image offset
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ofs <= `IPIA_OFS_FIRST;
        end else if (take_start) begin
            ofs <= `IPIA_OFS_FIRST;
        end else if (push && !at_last) begin
            ofs <= ofs + 8'h01;
        end
    end

    // slot position; stride of eighteen puts the sixth, seventh and
    // eighth quality bytes at 95, 113 and 131
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            port_idx <= 3'h0;
            slot_idx <= `IPIA_SLOT_QUALITY;
        end else if (take_start) begin
            port_idx <= 3'h0;
            slot_idx <= `IPIA_SLOT_QUALITY;
        end else if (push && (ofs >= `IPIA_OFS_SLOT_BASE)) begin
            if (slot_idx == `IPIA_SLOT_END) begin
                slot_idx <= `IPIA_SLOT_QUALITY;
                port_idx <= port_idx + 3'h1;
            end else begin
                slot_idx <= slot_idx + 5'h01;
            end
        end
    end

    // end-of-image pulse
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            done_out <= 1'b0;
        end else begin
            done_out <= push && at_last;
        end
    end

    assign busy_out = (state == ipia_pkg::IPIA_ST_SEND);

    // ----------------------------------------------------------------
    // digital-input bytes
    // ----------------------------------------------------------------
    // a pin driven as output reports what it drives
    function automatic logic pin_a(input ipia_pkg::ipia_port_s p);
        pin_a = p.dir_a ? p.channel_a_output : p.channel_a_input;
    endfunction

    function automatic logic pin_b(input ipia_pkg::ipia_port_s p);
        pin_b = p.dir_b ? p.channel_b_output : p.channel_b_input;
    endfunction

    // only the selected packing is built, port by port in one loop
    always_comb begin
        di_low = 8'h00;
        di_high = 8'h00;
        for (int k = 0; k < 8; k++) begin
            if (snap_pack == ipia_pkg::IPIA_PACK_PIN) begin
                di_low[k] = pin_a(snap[k]);
                di_high[k] = pin_b(snap[k]);
            end else if (k < 4) begin
                di_low[2*k] = pin_a(snap[k]);
                di_low[2*k+1] = pin_b(snap[k]);
                di_high[2*k] = pin_a(snap[k+4]);
                di_high[2*k+1] = pin_b(snap[k+4]);
            end
        end
    end

    // ----------------------------------------------------------------
    // header bytes
    // ----------------------------------------------------------------
    always_comb begin
        case (ofs)
            `IPIA_OFS_STATUS: begin
                hdr_byte = snap_di_valid ? `IPIA_STATUS_VALID
                                         : `IPIA_STATUS_INVALID;
            end
            `IPIA_OFS_DI_LOW: begin
                hdr_byte = di_low;
            end
            `IPIA_OFS_DI_HIGH: begin
                hdr_byte = di_high;
            end
            default: begin
                hdr_byte = `IPIA_ZERO_BYTE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // port slot bytes
    // ----------------------------------------------------------------
    always_comb begin
        ipia_pkg::ipia_port_s p;
        logic [4:0] d;
        p = snap[port_idx];
        d = slot_idx - `IPIA_SLOT_DATA;
        slot_byte = `IPIA_ZERO_BYTE;
        if (slot_idx == `IPIA_SLOT_QUALITY) begin
            slot_byte = p.port_quality_byte;
        end else if (slot_idx == `IPIA_SLOT_DUMMY) begin
            slot_byte = `IPIA_ZERO_BYTE;
        end else begin
            case (p.mode)
                ipia_pkg::IPIA_MODE_IOLINK: begin
                    // bytes beyond the device's own length pad with zero
                    if (d < p.pd_len) begin
                        slot_byte = p.pd[d[3:0]*8 +: 8];
                    end
                end
                ipia_pkg::IPIA_MODE_DIG_IN: begin
                    if (d == 5'h00) begin
                        slot_byte = {7'h00, p.channel_a_input};
                    end
                end
                ipia_pkg::IPIA_MODE_DIG_OUT: begin
                    if (d == 5'h00) begin
                        slot_byte = {7'h00, p.channel_a_output};
                    end
                end
                default: begin
                    slot_byte = `IPIA_ZERO_BYTE;
                end
            endcase
            // reserved tail of a digital slot stays zero
            if ((p.mode != ipia_pkg::IPIA_MODE_IOLINK) && (d != 5'h00)) begin
                slot_byte = `IPIA_ZERO_BYTE;
            end
        end
    end

    // ----------------------------------------------------------------
    // beat and fifo
    // ----------------------------------------------------------------
    always_comb begin
        beat.data = (ofs < `IPIA_OFS_SLOT_BASE) ? hdr_byte : slot_byte;
        beat.first = (ofs == `IPIA_OFS_FIRST);
        beat.last = at_last;
    end

    // the fifo absorbs up to FIFO_DEPTH bytes of the reader's stalls before the assembly stalls
    ipia_fifo #(
        .WIDTH($bits(ipia_pkg::ipia_beat_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .wr_valid_in(push),
        .wr_ready_out(fifo_ready),
        .wr_data_in(beat),
        .rd_valid_out(img_valid_out),
        .rd_ready_in(img_ready_in),
        .rd_data_out(fifo_rd)
    );

    assign img_out = ipia_pkg::ipia_beat_s'(fifo_rd);

endmodule

// ---- bench/ipia_assembler_properties.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// image stream checks
// ------------------------------------------------------------
module ipia_assembler_properties (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // control
    input wire logic start_in,
    input wire logic busy_out,
    input wire logic done_out,
    // stream
    input wire logic img_valid_out,
    input wire logic img_ready_in,
    input wire ipia_pkg::ipia_beat_s img_out
);
    logic [7:0] beat_cnt;

    // position in the image from accepted beats; restarts after last
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            beat_cnt <= 8'h00;
        end else if (img_valid_out && img_ready_in) begin
            beat_cnt <= img_out.last ? 8'h00 : beat_cnt + 8'h01;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    AST_START_BUSY: assert property (start_in && !busy_out |=> busy_out)
        else $error("busy missing after start");
    AST_FIRST_BYTE: assert property (start_in && !busy_out && !img_valid_out
        |-> ##2 img_valid_out && img_out.first) else $error("first byte late");
    AST_STATUS_CODE: assert property (img_valid_out && img_out.first
        |-> img_out.data inside {8'h00, 8'h01}) else $error("bad status byte");
    AST_FIRST_POS: assert property (img_valid_out && img_out.first
        |-> beat_cnt == 8'h00) else $error("first flag misplaced");
    AST_LAST_POS: assert property (img_valid_out && img_out.last
        |-> beat_cnt == 8'h93) else $error("last flag misplaced");
    AST_DUMMY_ZERO: assert property (img_valid_out
        && beat_cnt inside {8'h01, 8'h5F, 8'h71, 8'h83} |-> img_out.data == 8'h00)
        else $error("dummy byte not zero");
    AST_HOLD: assert property (img_valid_out && !img_ready_in
        |=> img_valid_out && $stable(img_out)) else $error("byte changed while stalled");
    AST_DONE_PULSE: assert property (done_out |=> !done_out)
        else $error("done longer than one cycle");
    AST_DONE_END: assert property (done_out |-> !busy_out && $past(busy_out))
        else $error("done without end of busy");
    AST_BUSY_LONG: assert property ($rose(busy_out) |-> busy_out [*8])
        else $error("busy too short");
    AST_DONE_AT_END: assert property ($fell(busy_out) |-> done_out)
        else $error("busy ended without done");
endmodule

bind ipia_assembler ipia_assembler_properties ipia_assembler_properties_inst (
    .clk_in(clk_in), .rst_in(rst_in), .start_in(start_in), .busy_out(busy_out),
    .done_out(done_out), .img_valid_out(img_valid_out), .img_ready_in(img_ready_in),
    .img_out(img_out));

// ---- bench/ipia_reader.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// fieldbus side reader of the image stream
// ------------------------------------------------------------
module ipia_reader (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // pacing: stalls most cycles when high
    input wire logic slow_in,
    // stream
    input wire logic img_valid_out,
    input wire ipia_pkg::ipia_beat_s img_out,
    output logic img_ready_in
);
    logic [7:0] got [1:148];
    logic [7:0] cnt;
    logic [2:0] pace;

    // ready only one cycle in eight when slow, so the fifo backs up
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pace <= 3'h0;
            img_ready_in <= 1'b0;
        end else begin
            pace <= pace + 3'h1;
            img_ready_in <= !slow_in || (pace == 3'h5);
        end
    end

    // store each accepted byte at its offset; first restarts at one
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt <= 8'h00;
        end else if (img_valid_out && img_ready_in) begin
            cnt <= img_out.first ? 8'h01 : cnt + 8'h01;
            got[img_out.first ? 8'h01 : cnt + 8'h01] <= img_out.data;
        end
    end
endmodule

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic start_in = 1'b0;
    logic di_valid_in = 1'b0;
    logic slow = 1'b0;
    ipia_pkg::ipia_pack_e pack_sel_in = ipia_pkg::IPIA_PACK_PORT;
    ipia_pkg::ipia_port_s [7:0] ports_in = '0;
    logic busy_out, done_out, img_valid_out, img_ready_in;
    ipia_pkg::ipia_beat_s img_out;
    int error_cnt = 0;
    int samples_checked = 0;

    ipia_assembler ipia_assembler_inst (.clk_in(clk_in), .rst_in(rst_in),
        .start_in(start_in), .busy_out(busy_out), .done_out(done_out),
        .ports_in(ports_in), .pack_sel_in(pack_sel_in), .di_valid_in(di_valid_in),
        .img_valid_out(img_valid_out), .img_ready_in(img_ready_in), .img_out(img_out));
    ipia_reader ipia_reader_inst (.clk_in(clk_in), .rst_in(rst_in), .slow_in(slow),
        .img_valid_out(img_valid_out), .img_out(img_out), .img_ready_in(img_ready_in));

    // ------------------------------------------------------------
    // expected image, worked out from the port configuration
    // ------------------------------------------------------------
    function automatic logic [7:0] exp_byte(int ofs);
        logic [7:0] b3, b4;
        logic a, b;
        int k;
        ipia_pkg::ipia_port_s p;
        b3 = 8'h00;
        b4 = 8'h00;
        for (int i = 0; i < 8; i++) begin
            a = ports_in[i].dir_a ? ports_in[i].channel_a_output : ports_in[i].channel_a_input;
            b = ports_in[i].dir_b ? ports_in[i].channel_b_output : ports_in[i].channel_b_input;
            if (pack_sel_in == ipia_pkg::IPIA_PACK_PIN) begin
                b3[i] = a;
                b4[i] = b;
            end else if (i < 4) begin
                b3[2*i] = a;
                b3[2*i+1] = b;
            end else begin
                b4[2*i-8] = a;
                b4[2*i-7] = b;
            end
        end
        if (ofs == 1) return di_valid_in ? 8'h01 : 8'h00;
        if (ofs == 2) return 8'h00;
        if (ofs == 3) return b3;
        if (ofs == 4) return b4;
        p = ports_in[(ofs-5)/18];
        k = (ofs - 5) % 18 - 2;
        if (k == -2) return p.port_quality_byte;
        if (k < 0) return 8'h00;
        case (p.mode)
            ipia_pkg::IPIA_MODE_IOLINK: return (k < p.pd_len) ? p.pd[8*k+:8] : 8'h00;
            ipia_pkg::IPIA_MODE_DIG_IN: return (k == 0) ? {7'h00, p.channel_a_input} : 8'h00;
            ipia_pkg::IPIA_MODE_DIG_OUT: return (k == 0) ? {7'h00, p.channel_a_output} : 8'h00;
            default: return 8'h00;
        endcase
    endfunction

    task automatic cmp8(string what, logic [7:0] exp, logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    // every mode appears on ports one to five; pd bytes are never zero, so reserved bytes show
    task automatic cfg(ipia_pkg::ipia_mode_e m5, ipia_pkg::ipia_mode_e m6,
                       ipia_pkg::ipia_mode_e m7, logic flip);
        for (int i = 0; i < 8; i++) begin
            ports_in[i].mode = (i < 5) ? ipia_pkg::ipia_mode_e'(i % 4) : (i == 5) ? m5 :
                (i == 6) ? m6 : m7;
            ports_in[i].port_quality_byte = 8'hC0 + 8'(i);
            ports_in[i].pd_len = (i == 5) ? 5'h10 : (i == 6) ? 5'h05 : (i == 7) ? 5'h00 : 5'h03;
            for (int j = 0; j < 16; j++) ports_in[i].pd[8*j+:8] = 8'h40 + 8'(16 * i + j);
            {ports_in[i].dir_a, ports_in[i].dir_b} = 2'(i) ^ {flip, 1'b0};
            {ports_in[i].channel_a_input, ports_in[i].channel_b_input} = 2'(i >> 1);
            {ports_in[i].channel_a_output, ports_in[i].channel_b_output} = ~2'(i >> 2);
        end
    endtask

    // start held for three edges: only the first is taken while busy
    task automatic run_img();
        @(posedge clk_in);
        #1 start_in = 1'b1;
        repeat (3) @(posedge clk_in);
        #1 start_in = 1'b0;
        for (int n = 0; n < 3000 && (busy_out !== 1'b0 || img_valid_out !== 1'b0); n++) begin
            @(posedge clk_in);
            #1;
        end
        cmp8("image drained", 8'h00, {6'h00, busy_out, img_valid_out});
        repeat (20) @(posedge clk_in);
        #1;
        cmp8("byte count", 8'h94, ipia_reader_inst.cnt);
        for (int o = 1; o <= 148; o++)
            cmp8($sformatf("offset %0d", o), exp_byte(o), ipia_reader_inst.got[o]);
    endtask

    task automatic t_iolink();
        cfg(ipia_pkg::IPIA_MODE_IOLINK, ipia_pkg::IPIA_MODE_IOLINK,
            ipia_pkg::IPIA_MODE_IOLINK, 1'b0);
        pack_sel_in = ipia_pkg::IPIA_PACK_PORT;
        di_valid_in = 1'b1;
        slow = 1'b0;
        run_img();
        $display("test iolink slots done");
    endtask

    task automatic t_digital();
        cfg(ipia_pkg::IPIA_MODE_DIG_IN, ipia_pkg::IPIA_MODE_DIG_OUT,
            ipia_pkg::IPIA_MODE_DIG_IN, 1'b1);
        pack_sel_in = ipia_pkg::IPIA_PACK_PIN;
        di_valid_in = 1'b0;
        slow = 1'b1;
        run_img();
        $display("test digital slots done");
    endtask

    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // clock, watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        forever #2 clk_in = ~clk_in;
    end

    // two images at most a few thousand cycles each
    initial begin
        repeat (20000) @(posedge clk_in);
        error_cnt++;
        summarize();
    end

    initial begin
        repeat (10) @(posedge clk_in);
        #1 rst_in = 1'b0;
        t_iolink();
        t_digital();
        summarize();
    end
endmodule
